// [design/cgw_top.v]
// Clock gear, watchdog and standby controller with APB register access
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "cgw_defs.vh"

module cgw_top #(
    parameter WD_BASE_EXP = `CGW_WD_BASE_EXP
) (
    // Clock and power-on reset
    input wire i_core_clk,
    input wire i_rst_n,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // Clock sources as one-cycle ticks on the core clock
    input wire i_osc_input,
    input wire i_pll_tick,
    // External reset pin, asynchronous
    input wire i_reset_pin_n,
    // Core and peripheral status
    input wire i_periph_irq,
    input wire i_stop_wake_irq,
    input wire i_cpu_bus_idle,
    input wire i_hold,
    // Clock enables and controls
    output reg o_cpu_clk_en,
    output reg o_bus_clk_en,
    output reg o_dma_clk_en,
    output reg o_periph_clk_en,
    output reg o_osc_run,
    output reg o_pll_run,
    output reg [1:0] o_pll_mult,
    output reg o_wdog_reset,
    output reg o_sys_reset
);

    localparam [2:0] ST_RUN = 3'h0;
    localparam [2:0] ST_SLEEP_REQ = 3'h1;
    localparam [2:0] ST_SLEEP = 3'h2;
    localparam [2:0] ST_STOP_REQ = 3'h3;
    localparam [2:0] ST_STOP = 3'h4;
    localparam [2:0] ST_WAKE = 3'h5;

    // Reset pin synchroniser
    reg pin_meta_q;
    reg pin_sync_q;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= i_reset_pin_n;
            pin_sync_q <= pin_meta_q;
        end
    end

    reg wdrst_q;
    wire soft_rst = ~pin_sync_q | wdrst_q;

    // APB decode
    wire setup = i_psel & ~i_penable;
    wire wr_acc = i_psel & i_penable & i_pwrite & o_pready;
    wire hit_gear = (i_paddr == `CGW_OFF_GEAR);
    wire hit_key = (i_paddr == `CGW_OFF_KEY);
    wire hit_pll = (i_paddr == `CGW_OFF_PLL);
    wire hit_stby = (i_paddr == `CGW_OFF_STANDBY);
    wire hit_wdctl = (i_paddr == `CGW_OFF_WDCTL);
    wire hit_stat = (i_paddr == `CGW_OFF_STATUS);
    wire hit_any = hit_gear | hit_key | hit_pll | hit_stby | hit_wdctl | hit_stat;

    // Control registers
    reg [1:0] cpu_gear_q;
    reg [1:0] per_gear_q;
    reg src_sel_q;
    reg [1:0] pll_mult_q;
    reg pll_halt_q;
    reg [1:0] wd_sel_q;
    reg [2:0] state_q;
    reg [2:0] step_q;

    // Gear and source select; other resets restore them too
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cpu_gear_q <= `CGW_RST_GEAR;
            per_gear_q <= `CGW_RST_GEAR;
            src_sel_q <= `CGW_RST_SRC;
        end else if (soft_rst) begin
            cpu_gear_q <= `CGW_RST_GEAR;
            per_gear_q <= `CGW_RST_GEAR;
            src_sel_q <= `CGW_RST_SRC;
        end else if (wr_acc && hit_gear) begin
            cpu_gear_q <= i_pwdata[`CGW_GEAR_CPU_HI -: 2];
            per_gear_q <= i_pwdata[`CGW_GEAR_PER_HI -: 2];
            if (i_pwdata[`CGW_GEAR_SRC] || !pll_halt_q) begin
                src_sel_q <= i_pwdata[`CGW_GEAR_SRC];
            end
        end
    end

    // PLL fields survive every reset but power-on
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pll_mult_q <= `CGW_RST_MULT;
            pll_halt_q <= `CGW_RST_HALT;
        end else if (wr_acc && hit_pll && src_sel_q) begin
            pll_mult_q <= i_pwdata[`CGW_PLL_MULT_HI -: 2];
            pll_halt_q <= i_pwdata[`CGW_PLL_HALT];
        end
    end

    // Watchdog interval select
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wd_sel_q <= `CGW_RST_WDSEL;
        end else if (soft_rst) begin
            wd_sel_q <= `CGW_RST_WDSEL;
        end else if (wr_acc && hit_wdctl) begin
            wd_sel_q <= i_pwdata[1:0];
        end
    end

    // Source clock: oscillator halved or PLL direct
    reg osc_half_q;
    reg src_prev_q;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_half_q <= 1'b0;
            src_prev_q <= 1'b1;
        end else begin
            if (i_osc_input) begin
                osc_half_q <= ~osc_half_q;
            end
            src_prev_q <= src_sel_q;
        end
    end
    // Both dividers restart together so a source change hits them at once
    wire src_tick = src_sel_q ? (i_osc_input & osc_half_q) : i_pll_tick;
    wire src_chg = src_sel_q ^ src_prev_q;

    // Two independent dividers, index 0 CPU and 1 peripheral
    wire [1:0] gear_tick;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_div
            reg [2:0] cnt_q;
            wire [1:0] code = (g == 0) ? cpu_gear_q : per_gear_q;
            wire [2:0] mask = ~(3'h7 << code);
            assign gear_tick[g] = src_tick & ((cnt_q & mask) == mask);
            always @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cnt_q <= 3'h0;
                end else if (src_chg) begin
                    cnt_q <= 3'h0;
                end else if (src_tick) begin
                    cnt_q <= cnt_q + 3'h1;
                end
            end
        end
    endgenerate

    // Standby requests from software
    wire stby_wr = wr_acc & hit_stby;
    wire stop_req = stby_wr & i_pwdata[`CGW_STBY_STOP] & ~i_periph_irq;
    wire sleep_req = stby_wr & ~i_pwdata[`CGW_STBY_STOP] & i_pwdata[`CGW_STBY_SLEEP];

    // Standby state machine; step_q counts clocks gated off in order
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_RUN;
            step_q <= 3'h0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    step_q <= 3'h0;
                    if (stop_req) begin
                        state_q <= ST_STOP_REQ;
                    end else if (sleep_req) begin
                        state_q <= ST_SLEEP_REQ;
                    end
                end
                ST_SLEEP_REQ: begin
                    if (soft_rst || i_periph_irq) begin
                        state_q <= ST_RUN;
                    end else if (i_cpu_bus_idle) begin
                        state_q <= ST_SLEEP;
                        step_q <= 3'h1;
                    end
                end
                ST_SLEEP: begin
                    // CPU then bus off; DMA and peripheral keep running
                    if (soft_rst || i_periph_irq) begin
                        state_q <= ST_WAKE;
                    end else if (step_q < 3'h2) begin
                        step_q <= step_q + 3'h1;
                    end
                end
                ST_STOP_REQ: begin
                    if (soft_rst) begin
                        state_q <= ST_RUN;
                    end else if (i_cpu_bus_idle) begin
                        state_q <= ST_STOP;
                        step_q <= 3'h1;
                    end
                end
                ST_STOP: begin
                    // Only the pin reset or a stop-capable interrupt gets out
                    if (!pin_sync_q || i_stop_wake_irq) begin
                        state_q <= ST_WAKE;
                    end else if (step_q < `CGW_STOP_STEPS) begin
                        step_q <= step_q + 3'h1;
                    end
                end
                ST_WAKE: begin
                    // Restart in reverse: oscillator, peripheral, DMA, bus, CPU
                    if (step_q == 3'h0) begin
                        state_q <= ST_RUN;
                    end else begin
                        step_q <= step_q - 3'h1;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                    step_q <= 3'h0;
                end
            endcase
        end
    end

    wire in_stop = (state_q == ST_STOP) | (state_q == ST_WAKE && step_q >= 3'h3);
    wire in_sleep = (state_q == ST_SLEEP);

    // Clock enables, each gated once its step has been reached
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cpu_clk_en <= 1'b0;
            o_bus_clk_en <= 1'b0;
            o_dma_clk_en <= 1'b0;
            o_periph_clk_en <= 1'b0;
            o_osc_run <= 1'b1;
            o_pll_run <= 1'b1;
            o_pll_mult <= `CGW_RST_MULT;
        end else begin
            o_cpu_clk_en <= gear_tick[0] & (step_q < 3'h1);
            o_bus_clk_en <= gear_tick[0] & (step_q < 3'h2);
            o_dma_clk_en <= gear_tick[0] & (step_q < 3'h3);
            o_periph_clk_en <= gear_tick[1] & (step_q < 3'h4);
            o_osc_run <= (step_q < `CGW_STOP_STEPS);
            o_pll_run <= ~pll_halt_q & ~in_stop;
            o_pll_mult <= pll_mult_q;
        end
    end

    // Key sequence: A5 arms, 5A right after clears, anything else disarms
    reg key_armed_q;
    reg key_clear_q;
    wire key_wr = wr_acc & hit_key;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            key_armed_q <= 1'b0;
            key_clear_q <= 1'b0;
        end else begin
            key_clear_q <= key_wr & key_armed_q & (i_pwdata[7:0] == `CGW_KEY_SECOND);
            if (key_wr) begin
                key_armed_q <= (i_pwdata[7:0] == `CGW_KEY_FIRST);
            end
        end
    end

    // Watchdog: a free count of base ticks; two overflows with no clear between
    // them trigger reset, so the reset lands between one and two periods.
    reg [`CGW_WD_CNT_W-1:0] wd_cnt_q;
    reg wd_ff_q;
    reg [1:0] wdrst_cnt_q;
    wire [4:0] wd_exp = WD_BASE_EXP[4:0] + {2'h0, wd_sel_q, 1'b0};
    wire [`CGW_WD_CNT_W-1:0] wd_mask = ~({`CGW_WD_CNT_W{1'b1}} << wd_exp);
    wire wd_ovf = src_tick & ((wd_cnt_q & wd_mask) == wd_mask);
    wire wd_hold_clr = in_sleep | (state_q == ST_STOP) | i_hold;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wd_cnt_q <= {`CGW_WD_CNT_W{1'b0}};
            wd_ff_q <= 1'b0;
            wdrst_q <= 1'b0;
            wdrst_cnt_q <= 2'h0;
        end else begin
            if (soft_rst) begin
                wd_cnt_q <= {`CGW_WD_CNT_W{1'b0}};
            end else if (src_tick) begin
                wd_cnt_q <= wd_cnt_q + {{(`CGW_WD_CNT_W-1){1'b0}}, 1'b1};
            end
            // An overflow in the clearing cycle still counts: set wins
            if (soft_rst || wd_hold_clr) begin
                wd_ff_q <= 1'b0;
            end else if (wd_ovf) begin
                wd_ff_q <= 1'b1;
            end else if (key_clear_q) begin
                wd_ff_q <= 1'b0;
            end
            // Request held across two peripheral ticks, at least one full cycle
            if (wdrst_q) begin
                if (gear_tick[1]) begin
                    wdrst_cnt_q <= wdrst_cnt_q + 2'h1;
                end
                if (gear_tick[1] && wdrst_cnt_q == `CGW_WDRST_TICKS - 2'h1) begin
                    wdrst_q <= 1'b0;
                end
            end else if (wd_ovf && wd_ff_q && !wd_hold_clr) begin
                wdrst_q <= 1'b1;
                wdrst_cnt_q <= 2'h0;
            end
        end
    end

    // Reset outputs
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wdog_reset <= 1'b0;
            o_sys_reset <= 1'b1;
        end else begin
            o_wdog_reset <= wdrst_q;
            o_sys_reset <= soft_rst;
        end
    end

    // Read data mux; the key register has no readable content
    reg [31:0] rdata;
    always @* begin
        rdata = 32'h0;
        if (hit_gear) begin
            rdata[`CGW_GEAR_CPU_HI -: 2] = cpu_gear_q;
            rdata[`CGW_GEAR_PER_HI -: 2] = per_gear_q;
            rdata[`CGW_GEAR_SRC] = src_sel_q;
        end else if (hit_pll) begin
            rdata[`CGW_PLL_MULT_HI -: 2] = pll_mult_q;
            rdata[`CGW_PLL_HALT] = pll_halt_q;
        end else if (hit_wdctl) begin
            rdata[1:0] = wd_sel_q;
        end else if (hit_stat) begin
            rdata[2:0] = state_q;
            rdata[6:4] = step_q;
            rdata[8] = wd_ff_q;
            rdata[9] = key_armed_q;
        end else if (hit_key) begin
            rdata = 32'h0;
        end
    end

    // APB answer: one wait-free access phase, data captured in setup
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup & ~hit_any;
            if (setup && !i_pwrite) begin
                o_prdata <= rdata;
            end
        end
    end

endmodule

// [design/cgw_defs.vh]
// Constants for the clock gear, watchdog and standby controller
// Functional notes
// - Key A5 then 5A clears watchdog flip-flop
// - Key register reads back undefined value
// - Unfinished key sequence within period causes reset
// - Stop, sleep or hold keep watchdog cleared
// - Interval select picks 2^15/17/19/21 base periods
// - Watchdog base is osc/2 or PLL clock
// - PLL control writable only while source select is 1
// - Multiplier code 00/01, upper reserved, power-on reset
// - PLL halt bit, reset only at power-on
// - Stop state halts PLL regardless of halt bit
// - Independent CPU and peripheral divider circuits
// - Gear codes 00..11 divide by 1,2,4,8
// - Source select switches both clocks at once
// - Stop state halts all clocks and oscillator
// - Stop exits on wake interrupt or reset pin
// - Sleep stops only CPU and bus clocks
// - Sleep exits on peripheral interrupt or any reset
// - Peripheral clock drives the peripheral blocks
// - Reset: source select 1, both gears divide by 8
// - Clearing source select ignored while PLL halted
// - Standby bit7 stop, bit6 sleep, stop blocked by irq
// - Stop gates CPU, bus, DMA, peripheral, then oscillator
`ifndef CGW_DEFS_VH
`define CGW_DEFS_VH

// Register byte offsets
`define CGW_OFF_GEAR 12'h000
`define CGW_OFF_KEY 12'h004
`define CGW_OFF_PLL 12'h008
`define CGW_OFF_STANDBY 12'h00C
`define CGW_OFF_WDCTL 12'h010
`define CGW_OFF_STATUS 12'h014

// Field positions
`define CGW_GEAR_CPU_HI 15
`define CGW_GEAR_PER_HI 11
`define CGW_GEAR_SRC 8
`define CGW_PLL_MULT_HI 15
`define CGW_PLL_HALT 11
`define CGW_STBY_STOP 7
`define CGW_STBY_SLEEP 6

// Reset values
`define CGW_RST_GEAR 2'h3
`define CGW_RST_SRC 1'h1
`define CGW_RST_MULT 2'h0
`define CGW_RST_HALT 1'h0
`define CGW_RST_WDSEL 2'h0

// Key bytes
`define CGW_KEY_FIRST 8'hA5
`define CGW_KEY_SECOND 8'h5A

// Watchdog timing: exponent of the shortest interval, counter width
`define CGW_WD_BASE_EXP 15
`define CGW_WD_CNT_W 23
// Peripheral ticks the watchdog reset request is held for
`define CGW_WDRST_TICKS 2'h2
// Number of gating steps from run to oscillator stop
`define CGW_STOP_STEPS 3'h5

`endif

// [dv/cgw_properties.sv]
// Port-level checker for the clock gear, watchdog and standby controller
`timescale 1ns/1ns
module cgw_properties (
    // Clock and reset
    input wire i_core_clk,
    input wire i_rst_n,
    // Inputs watched
    input wire i_psel,
    input wire i_penable,
    input wire i_hold,
    input wire i_reset_pin_n,
    // Outputs watched
    input wire o_pready,
    input wire o_pslverr,
    input wire o_cpu_clk_en,
    input wire o_dma_clk_en,
    input wire o_periph_clk_en,
    input wire o_osc_run,
    input wire o_pll_run,
    input wire o_wdog_reset,
    input wire o_sys_reset
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // Bus handshake: fixed one-cycle answer
    pready_answer_a: assert property (i_psel && !i_penable |=> o_pready) else $error("no pready");
    pready_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready too long");
    pslverr_pair_a: assert property (o_pslverr |-> o_pready) else $error("lone pslverr");
    // Oscillator off means the CPU, DMA and peripheral clock enables and the PLL are silent
    stop_quiet_a: assert property (!o_osc_run |-> !o_cpu_clk_en && !o_dma_clk_en
        && !o_periph_clk_en) else $error("clock pulse in stop");
    stop_pll_a: assert property (!o_osc_run |-> !o_pll_run) else $error("pll runs");
    // Pin and watchdog both end in a soft reset within a few edges
    pin_reset_a: assert property (!i_reset_pin_n |-> ##[1:3] o_sys_reset)
        else $error("pin ignored");
    wdog_sys_a: assert property (o_wdog_reset |-> ##[0:2] o_sys_reset)
        else $error("watchdog without reset");
    hold_quiet_a: assert property (i_hold [*3] |=> !$rose(o_wdog_reset))
        else $error("watchdog fired in hold");
    // Main scenarios reached
    stop_c: cover property ($fell(o_osc_run));
    wdog_c: cover property ($rose(o_wdog_reset));
    err_c: cover property (o_pslverr);
endmodule

bind cgw_top cgw_properties cgw_properties_i (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_hold(i_hold), .i_reset_pin_n(i_reset_pin_n), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_cpu_clk_en(o_cpu_clk_en), .o_dma_clk_en(o_dma_clk_en),
    .o_periph_clk_en(o_periph_clk_en), .o_osc_run(o_osc_run), .o_pll_run(o_pll_run),
    .o_wdog_reset(o_wdog_reset), .o_sys_reset(o_sys_reset)
);

// [dv/cgw_far_model.sv]
// Far-side model: oscillator and PLL tick sources plus CPU bus release
`timescale 1ns/1ns
module cgw_far_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Controls from the block and bus activity
    input wire logic i_osc_run,
    input wire logic i_pll_run,
    input wire logic i_psel,
    // Sources and bus status
    output logic o_osc_input,
    output logic o_pll_tick,
    output logic o_cpu_bus_idle
);
    logic [1:0] quiet_q;
    // A halted source gives no edges at all, so ticks follow the run levels
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            quiet_q <= 2'h0;
            o_osc_input <= 1'h0;
            o_pll_tick <= 1'h0;
        end else begin
            o_osc_input <= i_osc_run;
            o_pll_tick <= i_pll_run;
            quiet_q <= i_psel ? 2'h0 : (quiet_q == 2'h3 ? 2'h3 : quiet_q + 2'h1);
        end
    end
    // Bus counts as released after three quiet cycles, as a CPU finishing its last fetch
    assign o_cpu_bus_idle = (quiet_q == 2'h3);
endmodule

// [dv/cgw_top_tb_top.sv]
// Self-checking bench for the clock gear, watchdog and standby controller
`timescale 1ns/1ns
`include "cgw_defs.vh"
module cgw_top_tb_top;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, osc_tick, pll_tick, bus_idle, cpu_en, dma_en, per_en, bus_en;
    logic pin_n = 1, irq = 0, wake = 0, hold = 1, seen_wd = 0;
    logic osc_run, pll_run, wd_rst, sys_rst;
    logic [1:0] mult;
    int bad_count = 0, cmp_count = 0, n, m, nb, nd;

    always #5 clk = ~clk;
    // Latch any watchdog request so short pulses are not missed
    always @(posedge clk) if (wd_rst === 1'h1) seen_wd <= 1'h1;

    cgw_top #(.WD_BASE_EXP(4)) cgw_top_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_osc_input(osc_tick),
        .i_pll_tick(pll_tick), .i_reset_pin_n(pin_n), .i_periph_irq(irq),
        .i_stop_wake_irq(wake), .i_cpu_bus_idle(bus_idle), .i_hold(hold),
        .o_cpu_clk_en(cpu_en), .o_bus_clk_en(bus_en), .o_dma_clk_en(dma_en),
        .o_periph_clk_en(per_en), .o_osc_run(osc_run), .o_pll_run(pll_run),
        .o_pll_mult(mult), .o_wdog_reset(wd_rst), .o_sys_reset(sys_rst));
    cgw_far_model cgw_far_model_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_osc_run(osc_run),
        .i_pll_run(pll_run), .i_psel(psel), .o_osc_input(osc_tick), .o_pll_tick(pll_tick),
        .o_cpu_bus_idle(bus_idle));

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1 && ++t < 20);
        if (t >= 20) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd & mask, exp);
    endtask

    // Cycles between the second and third enable pulse, skipping any transition
    task automatic gap(input logic per, output int k);
        int p, t;
        p = 0;
        t = 0;
        k = 0;
        while (p < 3 && t < 400) begin
            @(negedge clk);
            t++;
            if (p == 2) k++;
            if ((per ? per_en : cpu_en) === 1'h1) p++;
        end
        // Hand back on a rising edge so the next stimulus lands there
        @(posedge clk);
    endtask

    task automatic cnt(input int c, output int nc, output int np);
        nc = 0;
        np = 0;
        nb = 0;
        nd = 0;
        repeat (c) begin
            @(negedge clk);
            if (cpu_en === 1'h1) nc++;
            if (per_en === 1'h1) np++;
            if (bus_en === 1'h1) nb++;
            if (dma_en === 1'h1) nd++;
        end
        @(posedge clk);
    endtask

    task automatic wt(input logic v);
        int t;
        t = 0;
        while ((osc_run !== v || sys_rst !== 1'h0) && t < 300) begin
            @(negedge clk);
            t++;
        end
        @(posedge clk);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        repeat (5) @(posedge clk);
        rdchk(`CGW_OFF_GEAR, 32'h0000CD00, 32'h0000CD00);
        rdchk(`CGW_OFF_PLL, 32'h0000C800, 32'h00000000);
        apb(1'h0, 12'h020, 32'h0);
        chk(err, 1'h1);
        apb(1'h1, `CGW_OFF_PLL, 32'h00004000);
        rdchk(`CGW_OFF_PLL, 32'h0000C800, 32'h00004000);
        chk(mult, 2'h1);
        apb(1'h1, `CGW_OFF_PLL, 32'h00004800);
        apb(1'h1, `CGW_OFF_GEAR, 32'h0000CC00);
        rdchk(`CGW_OFF_GEAR, 32'h00000100, 32'h00000100);
        chk(pll_run, 1'h0);
        apb(1'h1, `CGW_OFF_PLL, 32'h00004000);
        apb(1'h1, `CGW_OFF_GEAR, 32'h0000CC00);
        apb(1'h1, `CGW_OFF_PLL, 32'h00000000);
        rdchk(`CGW_OFF_PLL, 32'h0000C800, 32'h00004000);
        // Every gear code on the direct PLL source, then split gears and halved source
        for (int g = 0; g < 4; g++) begin
            apb(1'h1, `CGW_OFF_GEAR, (g << 14) | (g << 10));
            gap(1'h0, n);
            gap(1'h1, m);
            chk(n, 1 << g);
            chk(m, 1 << g);
        end
        apb(1'h1, `CGW_OFF_GEAR, 32'h00004C00);
        gap(1'h0, n);
        gap(1'h1, m);
        chk(n, 2);
        chk(m, 8);
        apb(1'h1, `CGW_OFF_GEAR, 32'h00000100);
        gap(1'h1, m);
        chk(m, 2);
        // Watchdog: steady key clears hold it off, a broken pair lets it fire
        hold <= 1'h0;
        seen_wd = 1'h0;
        repeat (12) begin
            apb(1'h1, `CGW_OFF_KEY, 32'h000000A5);
            apb(1'h1, `CGW_OFF_KEY, 32'h0000005A);
            repeat (10) @(posedge clk);
        end
        chk(seen_wd, 1'h0);
        // Longer interval tolerates clears too sparse for the shortest one;
        // hold keeps the flag clear while the interval changes under it
        hold <= 1'h1;
        apb(1'h1, `CGW_OFF_WDCTL, 32'h00000001);
        rdchk(`CGW_OFF_WDCTL, 32'h00000003, 32'h00000001);
        hold <= 1'h0;
        repeat (4) begin
            apb(1'h1, `CGW_OFF_KEY, 32'h000000A5);
            apb(1'h1, `CGW_OFF_KEY, 32'h0000005A);
            repeat (40) @(posedge clk);
        end
        chk(seen_wd, 1'h0);
        apb(1'h1, `CGW_OFF_WDCTL, 32'h00000000);
        n = 0;
        while (seen_wd !== 1'h1 && n < 40) begin
            apb(1'h1, `CGW_OFF_KEY, 32'h000000A5);
            apb(1'h1, `CGW_OFF_KEY, 32'h00000011);
            n++;
        end
        chk(seen_wd, 1'h1);
        hold <= 1'h1;
        wt(1'h1);
        rdchk(`CGW_OFF_GEAR, 32'h0000CD00, 32'h0000CD00);
        rdchk(`CGW_OFF_PLL, 32'h0000C800, 32'h00004000);
        // Stop, woken by a stop-capable interrupt and then by the pin
        apb(1'h1, `CGW_OFF_STANDBY, 32'h00000080);
        wt(1'h0);
        chk(osc_run, 1'h0);
        chk(pll_run, 1'h0);
        wake <= 1'h1;
        wt(1'h1);
        wake <= 1'h0;
        cnt(64, n, m);
        chk(n != 0, 1'h1);
        apb(1'h1, `CGW_OFF_STANDBY, 32'h00000080);
        wt(1'h0);
        pin_n <= 1'h0;
        repeat (3) @(posedge clk);
        pin_n <= 1'h1;
        wt(1'h1);
        chk(osc_run, 1'h1);
        // Pending interrupt refuses stop
        irq <= 1'h1;
        apb(1'h1, `CGW_OFF_STANDBY, 32'h00000080);
        repeat (20) @(posedge clk);
        chk(osc_run, 1'h1);
        irq <= 1'h0;
        // Sleep keeps peripherals clocked and wakes on their interrupt
        apb(1'h1, `CGW_OFF_STANDBY, 32'h00000040);
        repeat (20) @(posedge clk);
        cnt(64, n, m);
        chk(n, 0);
        chk(m != 0, 1'h1);
        chk(nb, 0);
        chk(nd != 0, 1'h1);
        irq <= 1'h1;
        repeat (20) @(posedge clk);
        cnt(64, n, m);
        chk(n != 0, 1'h1);
        irq <= 1'h0;
        wrap_up;
    end

    // Run needs about a thousand cycles; this bound only trips on a hang
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up;
    end
endmodule
